// [rtl/sbp_pkg.sv]
// Package for the switch buffer pacing and tag defaults register bank.
// Assumes a single switch clock at 100 MHz and word-indexed register numbers.
package sbp_pkg;
   localparam int          SBP_NUM_PORTS   = 3;
   localparam int          SBP_NUM_QUEUES  = 4;
   localparam int          SBP_PACE_W      = 13;
   localparam int          SBP_ADDR_W      = 16;
   // Register indices; byte address is four times the index
   localparam logic [15:0] SBP_IDX_PACE_00 = 16'h1c0d;
   localparam logic [15:0] SBP_IDX_PACE_02 = 16'h1c0e;
   localparam logic [15:0] SBP_IDX_PACE_10 = 16'h1c0f;
   localparam logic [15:0] SBP_IDX_PACE_12 = 16'h1c10;
   localparam logic [15:0] SBP_IDX_PACE_20 = 16'h1c11;
   localparam logic [15:0] SBP_IDX_PACE_22 = 16'h1c12;
   localparam logic [15:0] SBP_IDX_TAG_HOST = 16'h1c13;
   localparam logic [15:0] SBP_IDX_TAG_P1  = 16'h1c14;
   localparam logic [15:0] SBP_IDX_TAG_P2  = 16'h1c15;
   localparam logic [15:0] SBP_IDX_DROP_HOST = 16'h1c16;
   localparam logic [15:0] SBP_IDX_DROP_P1 = 16'h1c17;
   localparam logic [15:0] SBP_IDX_DROP_P2 = 16'h1c18;
   // Field positions
   localparam int          SBP_PACE_LO_LSB = 0;
   localparam int          SBP_PACE_HI_LSB = 13;
   localparam int          SBP_VID_LSB     = 0;
   localparam int          SBP_VID_W       = 12;
   localparam int          SBP_PRI_LSB     = 12;
   localparam int          SBP_PRI_W       = 3;
   // Reset values
   localparam logic [12:0] SBP_PACE_RST    = 13'h0000;
   localparam logic [11:0] SBP_VID_RST     = 12'h000;
   localparam logic [2:0]  SBP_PRI_RST     = 3'h0;
   localparam logic [31:0] SBP_DROP_RST    = 32'h0000_0000;
   localparam logic [31:0] SBP_DROP_MAX    = 32'hffff_ffff;
   // Pacing step time and its cycle count
   localparam int          SBP_CLK_NS      = 10;
   localparam int          SBP_PACE_STEP_NS = 20;
   localparam int          SBP_PACE_STEP_CYC = (SBP_PACE_STEP_NS + SBP_CLK_NS - 1) / SBP_CLK_NS;
   // AHB encodings
   localparam logic [1:0]  SBP_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  SBP_HTRANS_SEQ  = 2'h3;
endpackage

// [rtl/sbp_bank.sv]
// Register bank: egress pacing values, default tags, rate-drop counters,
// with per-queue pacing timers. Assumes an AHB-Lite master on hclk and
// drop pulses and byte strobes from same-clock logic.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
module sbp_bank
   import sbp_pkg::*;
#(
   parameter int NUM_PORTS  = SBP_NUM_PORTS,
   parameter int NUM_QUEUES = SBP_NUM_QUEUES
) (
   input  wire logic                              hclk,
   input  wire logic                              hresetn,
   input  wire logic                              hsel,
   input  wire logic [31:0]                       haddr,
   input  wire logic [1:0]                        htrans,
   input  wire logic                              hwrite,
   input  wire logic [2:0]                        hsize,
   input  wire logic [31:0]                       hwdata,
   input  wire logic                              hready,
   output logic      [31:0]                       hrdata,
   output logic                                   hreadyout,
   output logic                                   hresp,
   input  wire logic [NUM_PORTS-1:0]              drop_red,
   input  wire logic [NUM_PORTS-1:0]              drop_yellow,
   input  wire logic [NUM_PORTS*NUM_QUEUES-1:0]   egress_byte,
   output logic      [NUM_PORTS*NUM_QUEUES-1:0]   egress_ready,
   output logic      [NUM_PORTS*SBP_PRI_W-1:0]    tag_priority,
   output logic      [NUM_PORTS*SBP_VID_W-1:0]    tag_vlan_id
);
   localparam int NQ = NUM_PORTS * NUM_QUEUES;
   localparam int TW = SBP_PACE_W + 2;

   typedef struct packed {
      logic [NQ-1:0][SBP_PACE_W-1:0] pace;
      logic [NQ-1:0][TW-1:0]         timer;
      logic [NUM_PORTS-1:0][2:0]     pri;
      logic [NUM_PORTS-1:0][11:0]    vid;
      logic [NUM_PORTS-1:0][31:0]    drop;
      logic                          wr_pend;
      logic [15:0]                   wr_idx;
      logic [31:0]                   rdata;
   } sbp_state_t;

   sbp_state_t st_reg;
   sbp_state_t st_next;

   // Word index of a byte address
   function automatic logic [15:0] sbp_index(input logic [31:0] a);
      return a[17:2];
   endfunction

   // Timer load for N: (N+1) steps of 20 ns in clock cycles
   function automatic logic [TW-1:0] sbp_pace_cycles(input logic [SBP_PACE_W-1:0] n);
      logic [TW-1:0] steps;
      steps = {2'b00, n} + TW'(1);
      return TW'(steps * TW'(SBP_PACE_STEP_CYC));
   endfunction

   logic        addr_ok;
   logic [15:0] a_idx;
   logic        rd_take;
   logic [31:0] rd_word;
   int          rq;
   int          rp;

   assign a_idx   = sbp_index(haddr);
   assign addr_ok = hsel && hready && (htrans == SBP_HTRANS_NONSEQ || htrans == SBP_HTRANS_SEQ);
   assign rd_take = addr_ok && !hwrite;

   // Read mux; reserved bits read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      rq = 0;
      rp = 0;
      if (a_idx >= SBP_IDX_PACE_00 && a_idx <= SBP_IDX_PACE_22) begin
         rq = 2 * int'(a_idx - SBP_IDX_PACE_00);
         rd_word[SBP_PACE_HI_LSB +: SBP_PACE_W] = st_reg.pace[rq+1];
         rd_word[SBP_PACE_LO_LSB +: SBP_PACE_W] = st_reg.pace[rq];
      end else if (a_idx >= SBP_IDX_TAG_HOST && a_idx <= SBP_IDX_TAG_P2) begin
         rp = int'(a_idx - SBP_IDX_TAG_HOST);
         rd_word[SBP_PRI_LSB +: SBP_PRI_W] = st_reg.pri[rp];
         rd_word[SBP_VID_LSB +: SBP_VID_W] = st_reg.vid[rp];
      end else if (a_idx >= SBP_IDX_DROP_HOST && a_idx <= SBP_IDX_DROP_P2) begin
         rp = int'(a_idx - SBP_IDX_DROP_HOST);
         rd_word = st_reg.drop[rp];
      end
   end

   always_comb begin
      int wq;
      int wp;
      logic clr;
      logic ev;
      wq = 0;
      wp = 0;
      clr = 1'b0;
      ev = 1'b0;
      st_next = st_reg;
      st_next.wr_pend = addr_ok && hwrite;
      if (addr_ok) begin
         st_next.wr_idx = a_idx;
      end
      if (rd_take) begin
         st_next.rdata = rd_word;
      end
      // Data phase of a write
      if (st_reg.wr_pend) begin
         if (st_reg.wr_idx >= SBP_IDX_PACE_00 && st_reg.wr_idx <= SBP_IDX_PACE_22) begin
            wq = 2 * int'(st_reg.wr_idx - SBP_IDX_PACE_00);
            st_next.pace[wq+1] = hwdata[SBP_PACE_HI_LSB +: SBP_PACE_W];
            st_next.pace[wq]   = hwdata[SBP_PACE_LO_LSB +: SBP_PACE_W];
         end else if (st_reg.wr_idx >= SBP_IDX_TAG_HOST && st_reg.wr_idx <= SBP_IDX_TAG_P2) begin
            wp = int'(st_reg.wr_idx - SBP_IDX_TAG_HOST);
            st_next.pri[wp] = hwdata[SBP_PRI_LSB +: SBP_PRI_W];
            st_next.vid[wp] = hwdata[SBP_VID_LSB +: SBP_VID_W];
         end
      end
      // Drop counters; a write to them is ignored
      for (int p = 0; p < NUM_PORTS; p++) begin
         ev  = drop_red[p] | drop_yellow[p];
         clr = rd_take && (a_idx == SBP_IDX_DROP_HOST + 16'(p));
         if (clr) begin
            st_next.drop[p] = ev ? 32'h0000_0001 : SBP_DROP_RST;
         end else if (ev && st_reg.drop[p] != SBP_DROP_MAX) begin
            st_next.drop[p] = st_reg.drop[p] + 32'h0000_0001;
         end
      end
      // Per-queue byte pacing: after each byte, hold off (N+1) x 20 ns
      for (int q = 0; q < NQ; q++) begin
         if (egress_byte[q] && st_reg.timer[q] == '0) begin
            st_next.timer[q] = sbp_pace_cycles(st_reg.pace[q]) - TW'(1);
         end else if (st_reg.timer[q] != '0) begin
            st_next.timer[q] = st_reg.timer[q] - TW'(1);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg.pace    <= {NQ{SBP_PACE_RST}};
         st_reg.timer   <= '0;
         st_reg.pri     <= {NUM_PORTS{SBP_PRI_RST}};
         st_reg.vid     <= {NUM_PORTS{SBP_VID_RST}};
         st_reg.drop    <= {NUM_PORTS{SBP_DROP_RST}};
         st_reg.wr_pend <= 1'b0;
         st_reg.wr_idx  <= 16'h0000;
         st_reg.rdata   <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
      end
   end

   // Byte strobe is accepted only while ready
   always_comb begin
      for (int q = 0; q < NQ; q++) begin
         egress_ready[q] = (st_reg.timer[q] == '0);
      end
   end

   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         tag_priority[p*SBP_PRI_W +: SBP_PRI_W] = st_reg.pri[p];
         tag_vlan_id[p*SBP_VID_W +: SBP_VID_W]  = st_reg.vid[p];
      end
   end

   assign hrdata    = st_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
endmodule // sbp_bank

// [dv/sbp_bank_props.sv]
// Checker of the bank ports: read masks, host tag, pacing, drop counters.
// Assumes the slave's hreadyout is the bus hready.
`timescale 1ns/100ps
module sbp_bank_props #(parameter int NUM_PORTS = 3, parameter int NUM_QUEUES = 4) (
   input wire logic hclk, hresetn, hsel, hwrite, hreadyout,
   input wire logic [1:0] htrans,
   input wire logic [31:0] haddr, hwdata, hrdata,
   input wire logic [NUM_PORTS-1:0] drop_red, drop_yellow,
   input wire logic [NUM_PORTS*NUM_QUEUES-1:0] egress_byte, egress_ready,
   input wire logic [NUM_PORTS*3-1:0] tag_priority,
   input wire logic [NUM_PORTS*12-1:0] tag_vlan_id);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire rd = hsel && hreadyout && htrans[1] && !hwrite;
   wire wt = hsel && hreadyout && htrans[1] && hwrite && haddr == 32'h704c;
   wire r0 = rd && haddr == 32'h7058;
   wire d0 = drop_red[0] | drop_yellow[0];
   wire [11:0] hit = egress_byte & egress_ready;
   a_pace_mask: assert property (
      rd && haddr inside {[32'h7034:32'h7048]} |=> hrdata[31:26] == '0) else $error("pace");
   a_tag_mask: assert property (
      rd && haddr inside {[32'h704c:32'h7054]} |=> hrdata[31:15] == '0) else $error("tag");
   a_pace_gap: assert property (
      hit != '0 |=> (egress_ready & $past(hit)) == '0) else $error("gap");
   a_tag_vid: assert property (
      wt |=> ##1 tag_vlan_id[11:0] == $past(hwdata[11:0])) else $error("vid");
   a_tag_pri: assert property (
      wt |=> ##1 tag_priority[2:0] == $past(hwdata[14:12])) else $error("pri");
   a_tag_hold: assert property (
      !$past(wt, 2) |-> $stable(tag_vlan_id[11:0])) else $error("hold");
   a_read_clear: assert property (
      r0 && !d0 ##1 !d0 ##1 r0 |=> hrdata == '0) else $error("clear");
   a_clear_keep: assert property (
      r0 && d0 ##1 !d0 ##1 r0 |=> hrdata == 32'h0000_0001) else $error("lost");
   cover property (r0 && d0);
   cover property (wt);
   cover property (hit != '0);
endmodule // sbp_bank_props

// [dv/switch_buffer_pacing_tag_defaults_tb.sv]
// Bench of the bank: reset, read-back rows, drop counts, pacing.
// Assumes one zero-wait AHB-Lite slave on hclk.
`timescale 1ns/100ps
bind sbp_bank sbp_bank_props #(.NUM_PORTS(NUM_PORTS), .NUM_QUEUES(NUM_QUEUES)) u_props (.*);
module switch_buffer_pacing_tag_defaults_tb import sbp_pkg::*; ;
   typedef struct {logic [15:0] i; logic [31:0] d, e;} sbp_row_t;
   logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hreadyout, hresp;
   logic [1:0] htrans = '0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
   logic [2:0] drop_red = '0, drop_yellow = '0;
   logic [11:0] egress_byte = '0, egress_ready;
   logic [8:0] tag_priority;
   logic [35:0] tag_vlan_id;
   int miscompares = 0, samples_checked = 0, n;
   sbp_row_t rows [5] = '{'{16'h1c0d, 32'hffff_ffff, 32'h03ff_ffff},
      '{16'h1c13, 32'hffff_ffff, 32'h0000_7fff},
      '{16'h1c15, 32'h0000_5abc, 32'h0000_5abc},
      '{16'h1c18, 32'hffff_ffff, 32'h0},
      '{16'h1c19, 32'hffff_ffff, 32'h0}};
   always #5 hclk = ~hclk;
   sbp_bank uut (.*, .hsize(3'h2), .hready(hreadyout));
   task automatic report_and_stop(input bit hung);
      miscompares += hung;
      $display("checks %0d bad %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) $display("BAD %0t %s", $time, m);
      miscompares += int'(ok !== 1'b1);
   endtask
   // Drop mask dm rides the address phase only, so it lands on the clearing edge
   task automatic ahb(input logic w, logic [15:0] i, logic [31:0] d = '0, logic [2:0] dm = '0);
      htrans <= SBP_HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {14'h0, i, 2'h0};
      drop_red <= dm;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
         if (n == 50) report_and_stop(1'b1);
         if (p == 0) begin
            htrans <= '0;
            hwdata <= d;
            drop_red <= '0;
         end
      end
      r = hrdata;
   endtask
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      chk(egress_ready === 12'hfff && tag_vlan_id === '0 && tag_priority === '0, "rst");
      chk(hresp === 1'b0 && hreadyout === 1'b1 && hrdata === '0, "bus idle");
      for (int k = 16'h1c0d; k < 16'h1c19; k++) begin
         ahb(1'b0, 16'(k));
         chk(r === '0, "reset value");
      end
      foreach (rows[k]) begin
         ahb(1'b1, rows[k].i, rows[k].d);
         ahb(1'b0, rows[k].i);
         chk(r === rows[k].e, "read-back");
      end
      chk(tag_vlan_id === 36'ha_bc00_0fff && tag_priority === 9'h147, "tags");
      for (int k = 0; k < 5; k++) begin
         drop_red <= {1'b0, k != 3, 1'b0};
         drop_yellow <= {1'b0, k > 2, 1'b0};
         @(posedge hclk);
      end
      drop_yellow <= '0;
      ahb(1'b0, 16'h1c17);
      chk(r === 32'h5, "drop count");
      ahb(1'b0, 16'h1c16, '0, 3'h1);
      ahb(1'b0, 16'h1c16);
      chk(r === 32'h1, "drop at clear");
      ahb(1'b0, 16'h1c16);
      chk(r === '0, "clear on read");
      ahb(1'b1, 16'h1c0d, 32'h0000_0002);
      for (int q = 0; q < 2; q++) begin
         egress_byte <= 12'(1 << q);
         @(posedge hclk);
         egress_byte <= '0;
         for (n = 0; n < 50; n++) begin
            @(posedge hclk);
            if (egress_ready[q] === 1'b1) break;
         end
         chk(n === (q == 0 ? 5 : 1), "pacing gap");
      end
      report_and_stop(1'b0);
   end
endmodule // switch_buffer_pacing_tag_defaults_tb
